// ===== include/rdt_pkg.sv
/*
 * Shared constants and types for the RF driver and timer configuration
 * bank: register indices, reset values, field positions, gate codes and
 * the state record of the bank.
 * Assumes a 32-bit APB with word-aligned registers, byte address = 4*index.
 */
package rdt_pkg;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_MOD_WIDTH = 6'h24;
    localparam logic [5:0] IDX_RSVD = 6'h25;
    localparam logic [5:0] IDX_RX_GAIN = 6'h26;
    localparam logic [5:0] IDX_N_COND = 6'h27;
    localparam logic [5:0] IDX_P_CW = 6'h28;
    localparam logic [5:0] IDX_P_MOD = 6'h29;
    localparam logic [5:0] IDX_TMODE = 6'h2a;
    localparam logic [5:0] IDX_PSC_LO = 6'h2b;
    localparam logic [5:0] IDX_RELOAD_HI = 6'h2c;
    localparam logic [5:0] IDX_RELOAD_LO = 6'h2d;
    localparam logic [5:0] IDX_CTRL = 6'h30;
    localparam logic [5:0] IDX_STATUS = 6'h31;
    localparam logic [5:0] IDX_MASK = 6'h32;
    localparam logic [5:0] IDX_TVAL_HI = 6'h33;
    localparam logic [5:0] IDX_TVAL_LO = 6'h34;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_MOD_WIDTH = 8'h26;
    localparam logic [7:0] RST_RSVD = 8'h87;
    localparam logic [7:0] RST_RX_GAIN = 8'h48;
    localparam logic [7:0] RST_N_COND = 8'h88;
    localparam logic [7:0] RST_P_CW = 8'h20;
    localparam logic [7:0] RST_P_MOD = 8'h20;
    localparam logic [7:0] RST_TMODE = 8'h00;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GAIN_LSB = 4;
    localparam int GAIN_MSB = 6;
    localparam int TM_AUTO = 7;
    localparam int TM_GATE_MSB = 6;
    localparam int TM_GATE_LSB = 5;
    localparam int TM_RELOAD = 4;
    localparam int TM_PSC_MSB = 3;
    localparam int CT_PD = 0;
    localparam int CT_DRV1 = 1;
    localparam int CT_DRV2 = 2;
    localparam int CT_FORCE = 3;
    localparam int CT_EVEN = 4;
    localparam int CT_MULTI = 5;
    localparam int CT_START = 6;
    localparam int CT_STOP = 7;
    localparam int ST_EXPIRED = 0;
    localparam int ST_RUN = 7;

    localparam logic [1:0] GATE_SERIAL = 2'b01;
    localparam logic [1:0] GATE_AUX = 2'b10;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic {TMR_IDLE, TMR_RUN} rdt_tmr_t;

    typedef struct packed {
        logic [3:0] carrier_n_conductance;
        logic [3:0] modulated_n_conductance;
        logic [5:0] carrier_p_conductance;
        logic [5:0] modulated_p_conductance;
    } rdt_drive_t;

    typedef struct packed {
        logic [7:0] mod_width;
        logic [2:0] gain_sel;
        logic [3:0] cw_n;
        logic [3:0] mod_n;
        logic [5:0] cw_p;
        logic [5:0] mod_p;
        logic [7:0] tmode;
        logic [7:0] psc_lo;
        logic [15:0] reload;
        logic [5:0] ctrl;
        logic mask;
        logic flag;
        rdt_tmr_t tmr;
        logic [15:0] tval;
        logic [13:0] psc_cnt;
        logic pause;
        logic [7:0] pause_cnt;
        rdt_drive_t drive;
        logic [5:0] gain_db;
        logic [31:0] prdata;
        logic pslverr;
    } rdt_state_t;

    // Receiver gain in dB for each select code
    function automatic logic [5:0] rdt_gain_db(input logic [2:0] sel);
        case (sel)
            3'h0, 3'h2: rdt_gain_db = 6'h12;
            3'h1, 3'h3: rdt_gain_db = 6'h17;
            3'h4: rdt_gain_db = 6'h21;
            3'h5: rdt_gain_db = 6'h26;
            3'h6: rdt_gain_db = 6'h2b;
            default: rdt_gain_db = 6'h30;
        endcase
    endfunction : rdt_gain_db

endpackage : rdt_pkg

// ===== hdl/rdt_force_msb.sv
/*
 * Conductance field conditioner: passes a stored field through, with its
 * top bit held at one while soft power-down is active.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module rdt_force_msb #(
    parameter int W = 4
) (
    // Stored field and mode
    input wire logic [W-1:0] stored,
    input wire logic power_down,
    // Field as applied
    output logic [W-1:0] applied
);
    always_comb begin
        applied = stored;
        if (power_down) begin
            applied[W-1] = 1'b1;
        end
    end
endmodule : rdt_force_msb

// ===== hdl/rdt_config_regs.sv
/*
 * APB register bank for transmitter drive, receiver gain and timer set-up,
 * with the pause-width counter, prescaled timer and a timer interrupt.
 * Assumes carrier_tick pulses once per carrier period and all inputs are
 * synchronous to clk; zero-wait APB slave.
 */
`timescale 1ns/1ps
module rdt_config_regs
    import rdt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Carrier timing and modulator
    input wire logic carrier_tick,
    input wire logic mod_pause_start,
    output logic mod_pause,
    // Protocol events and gating pins
    input wire logic tx_end,
    input wire logic rx_fifth_bit,
    input wire logic contactless_serial_input,
    input wire logic auxiliary_pin_one,
    // Driver and receiver settings
    output rdt_drive_t drive,
    output logic [5:0] receiver_gain_db,
    output logic antenna_driver_one,
    output logic antenna_driver_two,
    output logic full_depth_ask_force,
    output logic soft_power_down,
    // Timer settings and state
    output logic [11:0] prescaler,
    output logic timer_auto_start,
    output logic [1:0] timer_gate_select,
    output logic timer_auto_reload,
    output logic [15:0] timer_value,
    output logic timer_running,
    output logic irq
);

    // ---------------------------------------------------------------
    // State and decode
    // ---------------------------------------------------------------
    rdt_state_t s_q;
    rdt_state_t s_d;

    logic [5:0] idx;
    logic aligned;
    logic wr_acc;
    logic rd_acc;
    logic setup;
    logic rd_hit;
    logic [7:0] rd_val;
    logic start_cmd;
    logic stop_cmd;
    logic start_ev;
    logic stop_ev;
    logic [13:0] divisor;
    logic tick;
    logic gate_ok;
    logic drv_on;
    logic [3:0] f_cw_n;
    logic [3:0] f_mod_n;
    logic [5:0] f_cw_p;
    logic [5:0] f_mod_p;

    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & aligned;
    assign rd_acc = psel & penable & ~pwrite & aligned;

    // ---------------------------------------------------------------
    // Soft power-down conditioning of the four conductances
    // ---------------------------------------------------------------
    rdt_force_msb #(.W(4)) u_cw_n (
        .stored(s_q.cw_n),
        .power_down(s_q.ctrl[CT_PD]),
        .applied(f_cw_n)
    );
    rdt_force_msb #(.W(4)) u_mod_n (
        .stored(s_q.mod_n),
        .power_down(s_q.ctrl[CT_PD]),
        .applied(f_mod_n)
    );
    rdt_force_msb #(.W(6)) u_cw_p (
        .stored(s_q.cw_p),
        .power_down(s_q.ctrl[CT_PD]),
        .applied(f_cw_p)
    );
    rdt_force_msb #(.W(6)) u_mod_p (
        .stored(s_q.mod_p),
        .power_down(s_q.ctrl[CT_PD]),
        .applied(f_mod_p)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        rd_hit = aligned;
        rd_val = 8'h00;

        // Read mux; reserved bits read as zero or as their reset value
        case (idx)
            IDX_MOD_WIDTH: rd_val = s_q.mod_width;
            IDX_RSVD: rd_val = RST_RSVD;
            IDX_RX_GAIN:
                rd_val = {1'b0, s_q.gain_sel, RST_RX_GAIN[3:0]};
            IDX_N_COND: rd_val = {s_q.cw_n, s_q.mod_n};
            IDX_P_CW: rd_val = {2'b00, s_q.cw_p};
            IDX_P_MOD: rd_val = {2'b00, s_q.mod_p};
            IDX_TMODE: rd_val = s_q.tmode;
            IDX_PSC_LO: rd_val = s_q.psc_lo;
            IDX_RELOAD_HI: rd_val = s_q.reload[15:8];
            IDX_RELOAD_LO: rd_val = s_q.reload[7:0];
            IDX_CTRL: rd_val = {2'b00, s_q.ctrl};
            IDX_STATUS: rd_val = {s_q.tmr == TMR_RUN, 6'h00, s_q.flag};
            IDX_MASK: rd_val = {7'h00, s_q.mask};
            IDX_TVAL_HI: rd_val = s_q.tval[15:8];
            IDX_TVAL_LO: rd_val = s_q.tval[7:0];
            default: rd_hit = 1'b0;
        endcase

        // Read data is captured in the setup cycle so it leaves a flop
        if (setup) begin
            s_d.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
            s_d.pslverr = ~rd_hit;
        end

        // Register writes take effect at the access edge
        if (wr_acc) begin
            case (idx)
                IDX_MOD_WIDTH: s_d.mod_width = pwdata[7:0];
                IDX_RX_GAIN: s_d.gain_sel = pwdata[GAIN_MSB:GAIN_LSB];
                IDX_N_COND: begin
                    s_d.cw_n = pwdata[7:4];
                    s_d.mod_n = pwdata[3:0];
                end
                IDX_P_CW: s_d.cw_p = pwdata[5:0];
                IDX_P_MOD: s_d.mod_p = pwdata[5:0];
                IDX_TMODE: s_d.tmode = pwdata[7:0];
                IDX_PSC_LO: s_d.psc_lo = pwdata[7:0];
                IDX_RELOAD_HI: s_d.reload[15:8] = pwdata[7:0];
                IDX_RELOAD_LO: s_d.reload[7:0] = pwdata[7:0];
                IDX_CTRL: begin
                    s_d.ctrl = pwdata[5:0];
                    start_cmd = pwdata[CT_START];
                    stop_cmd = pwdata[CT_STOP];
                end
                IDX_MASK: s_d.mask = pwdata[0];
                default: ;
            endcase
        end

        // Reading status clears the sticky flag; a new expiry below wins
        if (rd_acc && idx == IDX_STATUS) begin
            s_d.flag = 1'b0;
        end

        // Pause width counter in carrier periods
        if (s_q.pause) begin
            if (carrier_tick) begin
                if (s_q.pause_cnt == s_q.mod_width) begin
                    s_d.pause = 1'b0;
                end else begin
                    s_d.pause_cnt = s_q.pause_cnt + 8'h01;
                end
            end
        end else if (mod_pause_start) begin
            s_d.pause = 1'b1;
            s_d.pause_cnt = 8'h00;
        end

        // Timer
        case (s_q.tmr)
            TMR_IDLE: begin
                if (start_ev && !stop_ev) begin
                    s_d.tmr = TMR_RUN;
                    s_d.tval = s_q.reload;
                    s_d.psc_cnt = 14'h0000;
                end
            end
            TMR_RUN: begin
                if (stop_ev) begin
                    s_d.tmr = TMR_IDLE;
                end else if (start_ev) begin
                    s_d.tval = s_q.reload;
                    s_d.psc_cnt = 14'h0000;
                end else if (carrier_tick) begin
                    s_d.psc_cnt = tick ? 14'h0000 : s_q.psc_cnt + 14'h0001;
                    if (tick && gate_ok) begin
                        if (s_q.tval != 16'h0000) begin
                            s_d.tval = s_q.tval - 16'h0001;
                        end else if (s_q.tmode[TM_RELOAD]) begin
                            s_d.tval = s_q.reload;
                        end else begin
                            s_d.tmr = TMR_IDLE;
                            s_d.flag = 1'b1;
                        end
                    end
                end
            end
            default: s_d.tmr = TMR_IDLE;
        endcase

        // Applied drive settings, one cycle behind the stored fields
        s_d.drive.carrier_n_conductance = drv_on ? f_cw_n : 4'h0;
        s_d.drive.modulated_n_conductance = drv_on ? f_mod_n : 4'h0;
        s_d.drive.carrier_p_conductance = f_cw_p;
        s_d.drive.modulated_p_conductance =
            s_q.ctrl[CT_FORCE] ? 6'h00 : f_mod_p;
        s_d.gain_db = rdt_gain_db(s_q.gain_sel);
    end

    // ---------------------------------------------------------------
    // Timer helpers
    // ---------------------------------------------------------------
    assign start_ev = start_cmd | (s_q.tmode[TM_AUTO] & tx_end);
    assign stop_ev = stop_cmd
        | (s_q.tmode[TM_AUTO] & ~s_q.ctrl[CT_MULTI] & rx_fifth_bit);
    assign prescaler = {s_q.tmode[TM_PSC_MSB:0], s_q.psc_lo};
    // Divisor tops out at 8192 carrier periods, hence the 14-bit counter
    assign divisor = {1'b0, prescaler, 1'b0} + 14'h0001
        + {13'h0000, s_q.ctrl[CT_EVEN]};
    assign tick = carrier_tick
        && (s_q.psc_cnt == divisor - 14'h0001);
    // Code 11 has no gate source, so it runs ungated
    always_comb begin
        case (s_q.tmode[TM_GATE_MSB:TM_GATE_LSB])
            GATE_SERIAL: gate_ok = contactless_serial_input;
            GATE_AUX: gate_ok = auxiliary_pin_one;
            default: gate_ok = 1'b1;
        endcase
    end
    assign drv_on = s_q.ctrl[CT_DRV1] | s_q.ctrl[CT_DRV2];

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.mod_width <= RST_MOD_WIDTH;
            s_q.gain_sel <= RST_RX_GAIN[GAIN_MSB:GAIN_LSB];
            s_q.cw_n <= RST_N_COND[7:4];
            s_q.mod_n <= RST_N_COND[3:0];
            s_q.cw_p <= RST_P_CW[5:0];
            s_q.mod_p <= RST_P_MOD[5:0];
            s_q.tmode <= RST_TMODE;
            s_q.tmr <= TMR_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = s_q.pslverr;
    assign mod_pause = s_q.pause;
    assign drive = s_q.drive;
    assign receiver_gain_db = s_q.gain_db;
    assign antenna_driver_one = s_q.ctrl[CT_DRV1];
    assign antenna_driver_two = s_q.ctrl[CT_DRV2];
    assign full_depth_ask_force = s_q.ctrl[CT_FORCE];
    assign soft_power_down = s_q.ctrl[CT_PD];
    assign timer_auto_start = s_q.tmode[TM_AUTO];
    assign timer_gate_select = s_q.tmode[TM_GATE_MSB:TM_GATE_LSB];
    assign timer_auto_reload = s_q.tmode[TM_RELOAD];
    assign timer_value = s_q.tval;
    assign timer_running = (s_q.tmr == TMR_RUN);
    assign irq = s_q.flag & s_q.mask;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_pause_end;
        $fell(mod_pause) |->
            $past(carrier_tick && s_q.pause_cnt == s_q.mod_width);
    endproperty
    a_pause_end: assert property (p_pause_end)
        else $error("pause ended at wrong count");

    property p_gain_33;
        (s_q.gain_sel == 3'h4) ##1 (s_q.gain_sel == 3'h4)
            |-> receiver_gain_db == 6'h21;
    endproperty
    a_gain_33: assert property (p_gain_33)
        else $error("gain code 100 not 33 dB");

    property p_n_split;
        wr_acc && idx == IDX_N_COND ##1 drv_on && !soft_power_down
            |=> drive.carrier_n_conductance == $past(pwdata[7:4], 2)
            && drive.modulated_n_conductance == $past(pwdata[3:0], 2);
    endproperty
    a_n_split: assert property (p_n_split)
        else $error("n conductance nibbles misplaced");

    property p_pd_force;
        $past(soft_power_down && drv_on) |->
            drive.carrier_n_conductance[3]
            && drive.modulated_n_conductance[3]
            && drive.carrier_p_conductance[5];
    endproperty
    a_pd_force: assert property (p_pd_force)
        else $error("top bit not forced in power-down");

    property p_n_off;
        $past(!antenna_driver_one && !antenna_driver_two) |->
            drive.carrier_n_conductance == 4'h0
            && drive.modulated_n_conductance == 4'h0;
    endproperty
    a_n_off: assert property (p_n_off)
        else $error("n conductance applied with drivers off");

    property p_ask_force;
        $past(full_depth_ask_force) |->
            drive.modulated_p_conductance == 6'h00;
    endproperty
    a_ask_force: assert property (p_ask_force)
        else $error("modulation p conductance used under force");

    property p_tmode_wr;
        wr_acc && idx == IDX_TMODE |=>
            timer_auto_start == $past(pwdata[7])
            && timer_gate_select == $past(pwdata[6:5])
            && prescaler[11:8] == $past(pwdata[3:0]);
    endproperty
    a_tmode_wr: assert property (p_tmode_wr)
        else $error("timer mode fields misplaced");

    property p_rsvd_read;
        setup && !pwrite && paddr == {IDX_RSVD, 2'b00}
            |=> prdata == 32'h0000_0087;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved register read wrong");

    sequence s_fifth_bit;
        timer_running && timer_auto_start
            && !s_q.ctrl[CT_MULTI] && rx_fifth_bit && !start_cmd;
    endsequence
    property p_auto_stop;
        s_fifth_bit |=> !timer_running;
    endproperty
    a_auto_stop: assert property (p_auto_stop)
        else $error("timer kept running after fifth bit");

    property p_gate_hold;
        timer_running && tick && !stop_ev && !start_ev
            && timer_gate_select == GATE_SERIAL
            && !contactless_serial_input |=> $stable(timer_value);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("gated timer counted");

    sequence s_expire;
        timer_running && tick && gate_ok && !stop_ev && !start_ev
            && timer_value == 16'h0000 && !timer_auto_reload;
    endsequence
    property p_expire;
        s_expire |=> s_q.flag && !timer_running;
    endproperty
    a_expire: assert property (p_expire)
        else $error("expiry did not stop and flag");

    property p_tick_div;
        tick |-> s_q.psc_cnt == {1'b0, prescaler, 1'b0}
            + {13'h0000, s_q.ctrl[CT_EVEN]};
    endproperty
    a_tick_div: assert property (p_tick_div)
        else $error("timer tick at wrong divisor");

    property p_p_rsvd;
        setup && !pwrite && paddr == {IDX_P_MOD, 2'b00}
            |=> prdata[7:6] == 2'b00;
    endproperty
    a_p_rsvd: assert property (p_p_rsvd)
        else $error("reserved p bits read nonzero");

endmodule : rdt_config_regs

// ===== tb/rdt_config_regs_test.sv
/*
 * Self-checking bench for the RF drive and timer configuration bank.
 * Assumes the zero-wait APB slave and one carrier tick per clock.
 */
`timescale 1ns/1ps
module rdt_config_regs_test;
    import rdt_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic tick, pstart, mpause, txe, rx5, sin, aux;
    rdt_drive_t drive;
    logic [5:0] gain_db;
    logic drv1, drv2, ask, pd, auto_s, rl, running, irq;
    logic [11:0] psc;
    logic [1:0] gate;
    logic [15:0] tval;
    logic [7:0] rst_tab [7] = '{8'h26, 8'h87, 8'h48, 8'h88, 8'h20, 8'h20,
                                8'h00};
    logic [5:0] db_tab [8] = '{6'h12, 6'h17, 6'h12, 6'h17, 6'h21, 6'h26,
                               6'h2b, 6'h30};
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n, n1;

    always #25 clk = ~clk;

    rdt_config_regs rdt_config_regs_i (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .carrier_tick(tick), .mod_pause_start(pstart), .mod_pause(mpause),
        .tx_end(txe), .rx_fifth_bit(rx5), .contactless_serial_input(sin),
        .auxiliary_pin_one(aux), .drive(drive), .receiver_gain_db(gain_db),
        .antenna_driver_one(drv1), .antenna_driver_two(drv2),
        .full_depth_ask_force(ask), .soft_power_down(pd), .prescaler(psc),
        .timer_auto_start(auto_s), .timer_gate_select(gate),
        .timer_auto_reload(rl), .timer_value(tval),
        .timer_running(running), .irq(irq));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One idle cycle after each transfer keeps psel from being
    // assigned twice in one time step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(r, {24'h0, x});
    endtask : rd

    // One-cycle protocol event: transmit end, or fifth received bit
    task automatic pulse(input logic is_rx);
        txe <= ~is_rx;
        rx5 <= is_rx;
        @(posedge clk);
        txe <= 1'b0;
        rx5 <= 1'b0;
        @(posedge clk);
    endtask : pulse

    // Looks mid-cycle so the flag edge cannot race the sample
    task automatic wait_irq;
        n = 0;
        @(negedge clk);
        while (irq !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask : wait_irq

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tick, pstart, txe, rx5, sin, aux} = 6'h20;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (n1 = 0; n1 < 7; n1++) begin
            rd(8'h90 + 8'(4 * n1), rst_tab[n1]);
        end
        wr(8'h94, 8'hff);
        rd(8'h94, 8'h87);
        wr(8'h98, 8'hff);
        rd(8'h98, 8'h78);
        wr(8'ha0, 8'hff);
        rd(8'ha0, 8'h3f);
        wr(8'ha4, 8'hff);
        rd(8'ha4, 8'h3f);
        for (n1 = 0; n1 < 8; n1++) begin
            wr(8'h98, 8'(n1 << 4));
            chk(32'(gain_db), 32'(db_tab[n1]));
        end
        // Drivers on first, so the nibble split is watched as it lands
        wr(8'hc0, 8'h02);
        wr(8'h9c, 8'h5a);
        wr(8'ha0, 8'h15);
        wr(8'ha4, 8'h0c);
        chk(32'(drive), 32'({4'h5, 4'ha, 6'h15, 6'h0c}));
        wr(8'hc0, 8'h00);
        chk(32'(drive), 32'({8'h00, 6'h15, 6'h0c}));
        wr(8'hc0, 8'h05);
        chk(32'(drive), 32'({4'hd, 4'ha, 6'h35, 6'h2c}));
        chk(32'({pd, drv1, drv2, ask}), 32'ha);
        wr(8'hc0, 8'h0b);
        chk(32'(drive.modulated_p_conductance), 32'h0);
        chk(32'({pd, drv1, drv2, ask}), 32'hd);
        wr(8'ha8, 8'hf3);
        wr(8'hac, 8'h45);
        chk(32'(psc), 32'h345);
        chk(32'({auto_s, gate, rl}), 32'hf);
        wr(8'h90, 8'h03);
        pstart <= 1'b1;
        @(posedge clk);
        pstart <= 1'b0;
        n = 0;
        // Sample mid-cycle, away from the edge that moves the pause flag
        repeat (20) begin
            @(negedge clk);
            if (mpause === 1'b1) n++;
        end
        @(posedge clk);
        chk(n, 4);
        wr(8'ha8, 8'h00);
        wr(8'hac, 8'h01);
        wr(8'hb4, 8'h02);
        wr(8'hc8, 8'h01);
        wr(8'hc0, 8'h40);
        wait_irq();
        n1 = n;
        chk(32'(irq), 32'h1);
        rd(8'hc4, 8'h01);
        chk(32'(irq), 32'h0);
        wr(8'hc0, 8'h50);
        wait_irq();
        chk(n - n1, 3);
        rd(8'hc4, 8'h01);
        wr(8'hb4, 8'h40);
        wr(8'ha8, 8'h80);
        pulse(1'b0);
        chk(32'(running), 32'h1);
        pulse(1'b1);
        chk(32'(running), 32'h0);
        // Multi-frame: the fifth bit is ignored; a stop command or expiry ends it
        wr(8'hc0, 8'h20);
        pulse(1'b0);
        pulse(1'b1);
        chk(32'(running), 32'h1);
        wr(8'hc0, 8'h80);
        chk(32'(running), 32'h0);
        wr(8'ha8, 8'h20);
        sin <= 1'b0;
        wr(8'hc0, 8'h40);
        repeat (20) @(posedge clk);
        chk(32'(tval), 32'h40);
        sin <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'(tval < 16'h40), 32'h1);
        // Auto-reload: wraps to the reload value, never raises the flag
        wr(8'hb4, 8'h01);
        wr(8'ha8, 8'h10);
        wr(8'hc0, 8'h40);
        repeat (30) @(posedge clk);
        chk(32'({running, irq}), 32'h2);
        apb(1'b0, 8'h00, 8'h00);
        chk(32'(e), 32'h1);
        print_verdict();
    end
endmodule : rdt_config_regs_test
